/* design/self_test_pkg.sv */
package self_test_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_COMMAND   = 8'h00;  // Start or abort a test (write)
  localparam logic [7:0] OFS_TEST_NS   = 8'h04;  // Namespace the next test targets
  localparam logic [7:0] OFS_FORMAT    = 8'h08;  // Format request (write)
  localparam logic [7:0] OFS_FORMAT_NS = 8'h0C;  // Namespace a format names
  localparam logic [7:0] OFS_STATUS    = 8'h10;  // Run state, type, progress
  localparam logic [7:0] OFS_CONFIG    = 8'h14;  // Format attribute bits, policy
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;  // Sticky events (read only)
  localparam logic [7:0] OFS_IRQ_EN    = 8'h1C;  // Event enables
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h20;  // Write one to clear
  localparam logic [7:0] OFS_EXT_TIME  = 8'h24;  // Advertised extended time, minutes

  // Test codes in the command register low nibble
  localparam logic [3:0] CODE_SHORT    = 4'h1;
  localparam logic [3:0] CODE_EXTENDED = 4'h2;
  localparam logic [3:0] CODE_ABORT    = 4'hF;

  // Identifier meaning every namespace
  localparam logic [31:0] NS_ALL = 32'hFFFFFFFF;

  // Field positions
  localparam int FORMAT_SECURE_BIT = 0;  // Format register: secure erase flag
  localparam int CFG_ATTR_LSB      = 0;  // Config: format_attribute_bits [1:0]
  localparam int CFG_ABORT_ALLNS   = 2;  // Config: abort an all-namespace test
  localparam int CFG_ABORT_REMOVED = 3;  // Config: abort on namespace removal

  // Event bits in the interrupt registers
  localparam int EV_DONE    = 0;
  localparam int EV_ABORTED = 1;
  localparam int EV_RESUMED = 2;
  localparam int EV_COUNT   = 3;

  // Timing
  localparam longint CLK_HZ           = 40000000;
  localparam longint SHORT_LIMIT_S    = 120;  // Two minutes
  localparam longint SHORT_LIMIT_CYC  = SHORT_LIMIT_S * CLK_HZ;
  localparam logic [7:0] PCT_FULL     = 8'h64;  // 100 percent
  localparam logic [15:0] EXT_MIN_RESET = 16'h000A;  // Advertised extended minutes after reset

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b001,
    ST_SHORT    = 3'b010,
    ST_EXTENDED = 3'b100
  } run_state_type;

endpackage : self_test_pkg

/* design/progress_counter.sv */
// Divides elapsed run cycles into a 0..100 percent figure
module progress_counter
  import self_test_pkg::*;
#(
  parameter int CNT_W = 48
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             clear,       // Restart from zero
  input  wire logic             rewind,      // Back to start of current percent step
  input  wire logic             run,         // Advance one cycle
  input  wire logic [CNT_W-1:0] stepCycles,  // Cycles per percent
  output logic      [7:0]       percent,
  output logic                  finished
);

  logic [CNT_W-1:0] stepCount;  // Cycles within the current percent

  // Elaboration check: narrower step counters cannot hold a useful step
  if (CNT_W < 8) begin : g_bad_width
    $error("progress_counter: CNT_W too small");
  end

  // Step counter; a rewind repeats only the step that was running
  always_ff @(posedge core_clk) begin
    if (sys_rst || clear || rewind) begin
      stepCount <= '0;
    end else if (run && !finished) begin
      if (stepCount + 1'b1 >= stepCycles) begin
        stepCount <= '0;
      end else begin
        stepCount <= stepCount + 1'b1;
      end
    end
  end

  // Percent register, saturates at full
  always_ff @(posedge core_clk) begin
    if (sys_rst || clear) begin
      percent <= 8'h00;
    end else if (run && !finished && !rewind && stepCount + 1'b1 >= stepCycles) begin
      percent <= percent + 8'h01;
    end
  end

  assign finished = (percent == PCT_FULL);

endmodule : progress_counter

/* design/self_test_abort_control.sv */
// How it works
// - Short test aims to finish within two minutes
// - Progress percent kept current, readable by host
// - Controller reset aborts a running short test
// - Sanitize start aborts any running test
// - Test code F aborts any running test
// - Namespace removal may abort, per policy bit
// - Attribute 0: abort when namespace identifiers match
// - Attribute 0: format of all namespaces aborts
// - Attribute 0: single-namespace format, all-namespace test optional
// - Secure erase selects bit 1; set bit aborts always
// - Extended test paced to advertised time
// - Extended test survives controller reset, then resumes
// - Resume repeats only the interrupted segment
module self_test_abort_control
  import self_test_pkg::*;
#(
  parameter longint SHORT_CYCLES = SHORT_LIMIT_CYC,  // Short test length in cycles
  parameter longint MIN_CYCLES   = 60 * CLK_HZ       // Cycles per advertised minute
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        ctrlReset,      // Controller-level reset, level
  input  wire logic        sanitizeStart,  // Pulse: sanitize begins
  input  wire logic        nsRemoved,      // Pulse: namespace left the inventory
  input  wire logic [31:0] removedNs,      // Identifier that was removed
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  localparam int CNT_W = 48;

  run_state_type   state;           // Run state
  logic            extPending;      // Extended test paused by controller reset
  logic [31:0]     testNs;          // namespace_identifier of the running test
  logic [31:0]     nextTestNs;      // Identifier staged for the next start
  logic [31:0]     formatNs;        // Identifier staged for the next format
  logic [3:0]      cfg;             // format_attribute_bits and policy bits
  logic [15:0]     extMinutes;      // Advertised extended time
  logic [EV_COUNT-1:0] irqStat;     // Sticky events
  logic [EV_COUNT-1:0] irqEn;       // Event enables
  logic            lastResult;      // 1 when the last test was aborted
  logic            ctrlResetDly;    // For the falling edge of the reset

  logic            wrEn;
  logic            cmdWr;
  logic            fmtWr;
  logic            startShort;
  logic            startExt;
  logic            abortCode;
  logic            fmtAbort;
  logic            removeAbort;
  logic            abortNow;
  logic            resumeNow;
  logic            selAttr;
  logic [7:0]      percent;
  logic            finished;
  logic [CNT_W-1:0] stepCycles;
  logic            running;
  logic [31:0]     readWord;        // Register selected by paddr

  // Elaboration check: a percent step shorter than one cycle cannot be counted
  if (SHORT_CYCLES < 100 || MIN_CYCLES < 1) begin : g_bad_timing
    $error("self_test_abort_control: bad timing");
  end

  // Zero-wait APB slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wrEn    = psel && penable && pwrite;
  assign cmdWr   = wrEn && (paddr == OFS_COMMAND);
  assign fmtWr   = wrEn && (paddr == OFS_FORMAT);
  assign running = (state != ST_IDLE);

  // Command decode; a start is refused while a test runs or is paused
  assign abortCode  = cmdWr && (pwdata[3:0] == CODE_ABORT);
  assign startShort = cmdWr && (pwdata[3:0] == CODE_SHORT) && !running && !extPending
                      && !ctrlReset;
  assign startExt   = cmdWr && (pwdata[3:0] == CODE_EXTENDED) && !running && !extPending
                      && !ctrlReset;

  // Secure erase chooses attribute bit 1, otherwise bit 0
  assign selAttr = pwdata[FORMAT_SECURE_BIT] ? cfg[CFG_ATTR_LSB+1]
                                              : cfg[CFG_ATTR_LSB];

  // Format decision table
  always_comb begin
    fmtAbort = 1'b0;
    if (fmtWr && (running || extPending)) begin
      if (selAttr) begin
        fmtAbort = 1'b1;
      end else if (formatNs == NS_ALL) begin
        fmtAbort = 1'b1;
      end else if (testNs == NS_ALL) begin
        fmtAbort = cfg[CFG_ABORT_ALLNS];
      end else begin
        fmtAbort = (formatNs == testNs);
      end
    end
  end

  // Optional abort when the targeted namespace disappears
  assign removeAbort = nsRemoved && cfg[CFG_ABORT_REMOVED] && (running || extPending)
                       && (testNs == removedNs || testNs == NS_ALL);

  assign abortNow  = ((running || extPending) && (sanitizeStart || abortCode))
                     || fmtAbort || removeAbort
                     || (state == ST_SHORT && ctrlReset);
  // Resume on release of the controller reset
  assign resumeNow = extPending && ctrlResetDly && !ctrlReset && !abortNow;

  // Percent step length: short uses the two-minute budget, extended the advertised time
  assign stepCycles = (state == ST_SHORT)
                      ? CNT_W'(SHORT_CYCLES / 100)
                      : CNT_W'((longint'(extMinutes) * MIN_CYCLES) / 100);

  progress_counter #(
    .CNT_W (CNT_W)
  ) u_progress (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .clear      (startShort || startExt || abortNow),
    .rewind     (state == ST_EXTENDED && ctrlReset),
    .run        (running && !ctrlReset),
    .stepCycles (stepCycles),
    .percent    (percent),
    .finished   (finished)
  );

  // Run state machine
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state      <= ST_IDLE;
      extPending <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (resumeNow) begin
            state      <= ST_EXTENDED;
            extPending <= 1'b0;
          end else if (abortNow) begin
            extPending <= 1'b0;
          end else if (startShort) begin
            state <= ST_SHORT;
          end else if (startExt) begin
            state <= ST_EXTENDED;
          end
        end
        ST_SHORT: begin
          if (abortNow || finished) begin
            state <= ST_IDLE;
          end
        end
        ST_EXTENDED: begin
          if (abortNow || finished) begin
            state <= ST_IDLE;
          end else if (ctrlReset) begin
            // Parked, not lost: progress stays
            state      <= ST_IDLE;
            extPending <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Reset edge detector and result flag
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrlResetDly <= 1'b0;
      lastResult   <= 1'b0;
    end else begin
      ctrlResetDly <= ctrlReset;
      if (abortNow) begin
        lastResult <= 1'b1;
      end else if (startShort || startExt) begin
        lastResult <= 1'b0;
      end
    end
  end

  // Software-written registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      nextTestNs <= NS_ALL;
      testNs     <= NS_ALL;
      formatNs   <= NS_ALL;
      cfg        <= 4'h0;
      extMinutes <= EXT_MIN_RESET;
      irqEn      <= '0;
    end else begin
      if (wrEn && paddr == OFS_TEST_NS)   nextTestNs <= pwdata;
      if (wrEn && paddr == OFS_FORMAT_NS) formatNs   <= pwdata;
      if (wrEn && paddr == OFS_CONFIG)    cfg        <= pwdata[3:0];
      if (wrEn && paddr == OFS_EXT_TIME && pwdata[15:0] != 16'h0000) extMinutes <= pwdata[15:0];
      if (wrEn && paddr == OFS_IRQ_EN)    irqEn      <= pwdata[EV_COUNT-1:0];
      if (startShort || startExt)         testNs     <= nextTestNs;
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irqStat <= '0;
    end else begin
      for (int i = 0; i < EV_COUNT; i++) begin
        if ((i == EV_DONE    && running && finished && !abortNow) ||
            (i == EV_ABORTED && abortNow) ||
            (i == EV_RESUMED && resumeNow)) begin
          irqStat[i] <= 1'b1;
        end else if (wrEn && paddr == OFS_IRQ_CLR && pwdata[i]) begin
          irqStat[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(irqStat & irqEn);

  // Read mux, selected by the address alone
  always_comb begin
    readWord = 32'h0000_0000;
    case (paddr)
      OFS_TEST_NS:   readWord = nextTestNs;
      OFS_FORMAT_NS: readWord = formatNs;
      OFS_STATUS:    readWord = {15'h0000, lastResult, extPending, state, 4'h0, percent};
      OFS_CONFIG:    readWord = {28'h0000000, cfg};
      OFS_IRQ_STAT:  readWord = {29'h0, irqStat};
      OFS_IRQ_EN:    readWord = {29'h0, irqEn};
      OFS_EXT_TIME:  readWord = {16'h0000, extMinutes};
      default:       readWord = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup cycle, so it stands from a flip-flop
  // through the access cycle and the bus still needs no wait state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= readWord;
    end
  end

  // Assertions
  property p_short_reset;
    @(posedge core_clk) disable iff (sys_rst)
      (state == ST_SHORT && ctrlReset) |=> (state == ST_IDLE && irqStat[EV_ABORTED]);
  endproperty
  a_short_reset: assert property (p_short_reset) else $error("short test kept running");

  property p_sanitize;
    @(posedge core_clk) disable iff (sys_rst)
      (running && sanitizeStart) |=> (state == ST_IDLE && !extPending);
  endproperty
  a_sanitize: assert property (p_sanitize) else $error("sanitize did not abort");

  property p_abort_code;
    @(posedge core_clk) disable iff (sys_rst)
      ((running || extPending) && abortCode) |=> (!running && !extPending && lastResult);
  endproperty
  a_abort_code: assert property (p_abort_code) else $error("abort code ignored");

  property p_fmt_all;
    @(posedge core_clk) disable iff (sys_rst)
      (running && fmtWr && formatNs == NS_ALL) |=> (state == ST_IDLE);
  endproperty
  a_fmt_all: assert property (p_fmt_all) else $error("format of all did not abort");

  property p_fmt_match;
    @(posedge core_clk) disable iff (sys_rst)
      (running && fmtWr && !selAttr && formatNs != NS_ALL && testNs != NS_ALL
       && formatNs != testNs && !sanitizeStart && !finished && !ctrlReset && !nsRemoved)
      |=> (state == $past(state));
  endproperty
  a_fmt_match: assert property (p_fmt_match) else $error("wrong namespace abort");

  property p_secure;
    @(posedge core_clk) disable iff (sys_rst)
      (running && fmtWr && selAttr) |=> !running;
  endproperty
  a_secure: assert property (p_secure) else $error("attribute set did not abort");

  property p_ext_persist;
    @(posedge core_clk) disable iff (sys_rst)
      (state == ST_EXTENDED && ctrlReset && !abortNow && !finished) |=> extPending;
  endproperty
  a_ext_persist: assert property (p_ext_persist) else $error("extended test lost");

  property p_progress_held;
    @(posedge core_clk) disable iff (sys_rst)
      (extPending && !abortNow) |=> (percent == $past(percent));
  endproperty
  a_progress_held: assert property (p_progress_held) else $error("progress lost");

  property p_removed;
    @(posedge core_clk) disable iff (sys_rst)
      (running && nsRemoved && cfg[CFG_ABORT_REMOVED] && removedNs == testNs) |=> !running;
  endproperty
  a_removed: assert property (p_removed) else $error("namespace removal ignored");

  property p_resume;
    @(posedge core_clk) disable iff (sys_rst)
      (extPending && $fell(ctrlReset) && !abortNow)
      |=> (state == ST_EXTENDED && irqStat[EV_RESUMED]);
  endproperty
  a_resume: assert property (p_resume) else $error("parked test not resumed");

endmodule : self_test_abort_control

/* testbench/host_model.sv */
// Host software side: issues register commands over APB
module host_model (
  input  wire logic        core_clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // One transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Slave may stretch; the bench timeout ends a hang
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic apbWrite(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : apbWrite

  task automatic apbRead(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : apbRead
endmodule : host_model

/* testbench/self_test_abort_control_tb_top.sv */
// Self-checking bench for the self-test run and abort control
module self_test_abort_control_tb_top
  import self_test_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] MST = 32'h0000_7000;  // State field
  logic        coreClk;
  logic        sysRst;
  logic        ctrlReset;
  logic        sanitizeStart;
  logic        nsRemoved;
  logic [31:0] removedNs;
  logic        psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          mismatches = 0;
  int          numChecks = 0;
  int          cycles = 0;

  // Short test 1000 cycles, one advertised minute 10 cycles: keeps the run brief
  self_test_abort_control #(.SHORT_CYCLES(1000), .MIN_CYCLES(10)) i_dut (
    .core_clk(coreClk), .sys_rst(sysRst), .ctrlReset(ctrlReset),
    .sanitizeStart(sanitizeStart), .nsRemoved(nsRemoved), .removedNs(removedNs),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  host_model i_host (
    .core_clk(coreClk), .prdata(prdata), .pready(pready), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // Clock, 25 ns period
  initial begin
    coreClk = 1'b0;
    forever #12.5 coreClk = ~coreClk;
  end

  // Hang guard: far above the roughly 1600 cycles the tests need
  always @(posedge coreClk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      printVerdict();
    end
  end

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : printVerdict

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Read a register and compare the masked word
  task automatic rdChk(input string n, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    logic [31:0] d;
    i_host.apbRead(a, d);
    chk(n, e, d & m);
  endtask : rdChk

  function automatic logic [31:0] stv(input run_state_type s);
    return {17'h0, s, 12'h0};
  endfunction : stv

  task automatic wt(input int n);
    repeat (n) @(posedge coreClk);
  endtask : wt

  task automatic start(input logic [3:0] code, input logic [31:0] ns);
    i_host.apbWrite(OFS_TEST_NS, ns);
    i_host.apbWrite(OFS_COMMAND, {28'h0, code});
  endtask : start

  // Pulse the controller reset for n cycles
  task automatic ctrlPulse(input int n);
    ctrlReset <= 1'b1;
    wt(n);
    ctrlReset <= 1'b0;
  endtask : ctrlPulse

  task automatic testReset();
    rdChk("status", OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_1000);
    rdChk("unmapped", 8'h3C, 32'hFFFF_FFFF, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    chk("pready", 32'h1, {31'h0, pready});
    chk("pslverr", 32'h0, {31'h0, pslverr});
    // A zero advertised time is refused, the reset value stays
    i_host.apbWrite(OFS_EXT_TIME, 32'h0);
    rdChk("exttime", OFS_EXT_TIME, 32'hFFFF_FFFF, {16'h0, EXT_MIN_RESET});
    $display("test reset done");
  endtask : testReset

  task automatic testAbortCode();
    logic [31:0] p1, p2;
    i_host.apbWrite(OFS_IRQ_EN, 32'h7);
    start(CODE_SHORT, 32'h1);
    rdChk("short", OFS_STATUS, MST, stv(ST_SHORT));
    // A second start while a test runs is refused
    i_host.apbWrite(OFS_COMMAND, {28'h0, CODE_EXTENDED});
    rdChk("refused", OFS_STATUS, MST, stv(ST_SHORT));
    i_host.apbRead(OFS_STATUS, p1);
    wt(50);
    i_host.apbRead(OFS_STATUS, p2);
    chk("progress", 32'h1, {31'h0, p2[7:0] > p1[7:0]});
    i_host.apbWrite(OFS_COMMAND, {28'h0, CODE_ABORT});
    rdChk("abortF", OFS_STATUS, MST | 32'h1_0000, stv(ST_IDLE) | 32'h1_0000);
    chk("irq", 32'h1, {31'h0, irq});
    i_host.apbWrite(OFS_IRQ_CLR, 32'h7);
    wt(1);
    chk("irqclr", 32'h0, {31'h0, irq});
    // Masked: event still lands in status, line stays low
    i_host.apbWrite(OFS_IRQ_EN, 32'h0);
    start(CODE_EXTENDED, 32'h1);
    i_host.apbWrite(OFS_COMMAND, {28'h0, CODE_ABORT});
    rdChk("abortFext", OFS_STATUS, MST, stv(ST_IDLE));
    rdChk("irqstat", OFS_IRQ_STAT, 32'h7, 32'h2);
    chk("irqmask", 32'h0, {31'h0, irq});
    $display("test abort code done");
  endtask : testAbortCode

  task automatic testCtrlReset();
    i_host.apbWrite(OFS_IRQ_CLR, 32'h7);
    start(CODE_SHORT, 32'h1);
    wt(10);
    ctrlPulse(3);
    rdChk("shortreset", OFS_STATUS, MST, stv(ST_IDLE));
    i_host.apbWrite(OFS_IRQ_CLR, 32'h7);
    start(CODE_EXTENDED, 32'h1);
    wt(20);
    ctrlReset <= 1'b1;
    // Twenty cycles at one percent per cycle, held while parked
    rdChk("parked", OFS_STATUS, 32'h80FF, 32'h8014);
    ctrlReset <= 1'b0;
    wt(3);
    rdChk("resumed", OFS_STATUS, MST | 32'h8000, stv(ST_EXTENDED));
    wt(200);
    rdChk("extdone", OFS_STATUS, MST | 32'hFF, stv(ST_IDLE) | 32'h64);
    rdChk("extev", OFS_IRQ_STAT, 32'h7, 32'h5);
    $display("test controller reset done");
  endtask : testCtrlReset

  task automatic testSanitize();
    start(CODE_EXTENDED, 32'h1);
    wt(5);
    sanitizeStart <= 1'b1;
    wt(1);
    sanitizeStart <= 1'b0;
    rdChk("sanitize", OFS_STATUS, MST, stv(ST_IDLE));
    $display("test sanitize done");
  endtask : testSanitize

  // Rows: config, secure erase, test namespace, format namespace, abort expected
  task automatic testFormat();
    logic [31:0] cfg[8] = '{32'h0, 32'h0, 32'h0, 32'h2, 32'h1, 32'h1, 32'h4, 32'h0};
    logic        sec[8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [31:0] tns[8] = '{32'h5, 32'h5, 32'h5, 32'h5, 32'h5, 32'h5, NS_ALL, NS_ALL};
    logic [31:0] fns[8] = '{32'h5, 32'h6, NS_ALL, 32'h6, 32'h6, 32'h6, 32'h5, 32'h5};
    logic        ab[8]  = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 8; i++) begin
      i_host.apbWrite(OFS_CONFIG, cfg[i]);
      start(CODE_SHORT, tns[i]);
      i_host.apbWrite(OFS_FORMAT_NS, fns[i]);
      i_host.apbWrite(OFS_FORMAT, {31'h0, sec[i]});
      rdChk("format", OFS_STATUS, MST, ab[i] ? stv(ST_IDLE) : stv(ST_SHORT));
      i_host.apbWrite(OFS_COMMAND, {28'h0, CODE_ABORT});
    end
    // Removal of the targeted namespace with the policy bit set
    i_host.apbWrite(OFS_CONFIG, 32'h8);
    start(CODE_SHORT, 32'h9);
    removedNs <= 32'h9;
    nsRemoved <= 1'b1;
    wt(1);
    nsRemoved <= 1'b0;
    rdChk("removed", OFS_STATUS, MST, stv(ST_IDLE));
    $display("test format done");
  endtask : testFormat

  task automatic testShortDone();
    i_host.apbWrite(OFS_IRQ_CLR, 32'h7);
    start(CODE_SHORT, 32'h1);
    wt(1020);
    rdChk("shortdone", OFS_STATUS, 32'h1_70FF, stv(ST_IDLE) | 32'h64);
    rdChk("doneev", OFS_IRQ_STAT, 32'h7, 32'h1);
    $display("test short done");
  endtask : testShortDone

  // Main sequence: reset for 4 cycles, then each scenario
  initial begin
    sysRst = 1'b1;
    ctrlReset = 1'b0;
    sanitizeStart = 1'b0;
    nsRemoved = 1'b0;
    removedNs = 32'h0;
    wt(4);
    sysRst <= 1'b0;
    testReset();
    testAbortCode();
    testCtrlReset();
    testSanitize();
    testFormat();
    testShortDone();
    printVerdict();
  end
endmodule : self_test_abort_control_tb_top
